/* File: rtl/clock_switch_regs.svh */
`ifndef CLOCK_SWITCH_REGS_SVH
`define CLOCK_SWITCH_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CLKSW_ADDR_REQUEST 12'h000
`define CLKSW_ADDR_CURRENT 12'h004
`define CLKSW_ADDR_STATUS  12'h008

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CLKSW_SRC_F  6:4
`define CLKSW_DIV_F  3:0
`define CLKSW_SEL_F  6:0
`define CLKSW_HOLD_B 7
`define CLKSW_DONE_B 4
`define CLKSW_NSR_B  3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CLKSW_DIV_RST_FAST  4'h2
`define CLKSW_DIV_RST_OTHER 4'h0

// ----------------------------------------------------------------------
// timing: gate-off settle time per switch step
// ----------------------------------------------------------------------
`define CLKSW_CLK_PERIOD_PS 5000
`define CLKSW_SETTLE_PS     20000
`define CLKSW_SETTLE_CYC \
  ((`CLKSW_SETTLE_PS + `CLKSW_CLK_PERIOD_PS - 1) / `CLKSW_CLK_PERIOD_PS)

`endif

/* File: rtl/clock_switch_pkg.sv */
package clock_switch_pkg;

  // source and pll combinations
  typedef enum logic [2:0] {
    SRC_RSVD0     = 3'h0,
    SRC_FAST_PLL2 = 3'h1,
    SRC_EXT_PLL4  = 3'h2,
    SRC_RSVD3     = 3'h3,
    SRC_RSVD4     = 3'h4,
    SRC_SLOW      = 3'h5,
    SRC_FAST      = 3'h6,
    SRC_EXT       = 3'h7
  } source_t;

  // break-before-make sequencer
  typedef enum logic [1:0] {
    SEQ_IDLE     = 2'h0,
    SEQ_GATE_OFF = 2'h1,
    SEQ_SETTLE   = 2'h2,
    SEQ_GATE_ON  = 2'h3
  } seq_state_t;

endpackage

/* File: rtl/clock_switch_if.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// control side to sequencer
// ----------------------------------------------------------------------
interface clock_switch_if;
  logic       start;
  logic [2:0] tgt_src;
  logic [3:0] tgt_div;
  logic       busy;
  logic       done;
  logic       gate_en;
  logic [2:0] out_src;
  logic [3:0] out_div;

  modport ctrl (
    output start, tgt_src, tgt_div,
    input  busy, done, gate_en, out_src, out_div
  );
  modport seq (
    input  start, tgt_src, tgt_div,
    output busy, done, gate_en, out_src, out_div
  );
endinterface

/* File: rtl/clock_switch_sequencer.sv */
`timescale 1ns/10ps
`include "clock_switch_regs.svh"
module clock_switch_sequencer #(
  parameter int unsigned SETTLE_CYC = `CLKSW_SETTLE_CYC
) (
  // clock and reset
  input  logic           pclk,
  input  logic           presetn,
  // control side
  clock_switch_if.seq    sw
);
  localparam int unsigned CW = $clog2(SETTLE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE_CYC - 1);

  clock_switch_pkg::seq_state_t state_q;
  logic [CW-1:0]                cnt_q;
  logic [2:0]                   tgt_src_q;
  logic [3:0]                   tgt_div_q;

  assign sw.busy = (state_q != clock_switch_pkg::SEQ_IDLE);

  // state walk: gate off, drain, reselect, settle, gate on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= clock_switch_pkg::SEQ_IDLE;
    end else begin
      unique case (state_q)
        clock_switch_pkg::SEQ_IDLE: begin
          if (sw.start) begin
            state_q <= clock_switch_pkg::SEQ_GATE_OFF;
          end
        end
        clock_switch_pkg::SEQ_GATE_OFF: begin
          if (cnt_q == LAST) begin
            state_q <= clock_switch_pkg::SEQ_SETTLE;
          end
        end
        clock_switch_pkg::SEQ_SETTLE: begin
          if (cnt_q == LAST) begin
            state_q <= clock_switch_pkg::SEQ_GATE_ON;
          end
        end
        clock_switch_pkg::SEQ_GATE_ON: begin
          state_q <= clock_switch_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // settle counter, restarts at each step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (state_q == clock_switch_pkg::SEQ_IDLE || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // target captured once so a late request cannot tear a switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_src_q <= clock_switch_pkg::SRC_FAST;
      tgt_div_q <= `CLKSW_DIV_RST_FAST;
    end else if (sw.start && !sw.busy) begin
      tgt_src_q <= sw.tgt_src;
      tgt_div_q <= sw.tgt_div;
    end
  end

  // select changes only while the gate is closed, no runt pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw.gate_en <= 1'b1;
      sw.out_src <= clock_switch_pkg::SRC_FAST;
      sw.out_div <= `CLKSW_DIV_RST_FAST;
      sw.done    <= 1'b0;
    end else begin
      sw.done <= 1'b0;
      if (state_q == clock_switch_pkg::SEQ_IDLE && sw.start) begin
        sw.gate_en <= 1'b0;
      end
      if (state_q == clock_switch_pkg::SEQ_GATE_OFF && cnt_q == LAST) begin
        sw.out_src <= tgt_src_q;
        sw.out_div <= tgt_div_q;
      end
      if (state_q == clock_switch_pkg::SEQ_GATE_ON) begin
        sw.gate_en <= 1'b1;
        sw.done    <= 1'b1;
      end
    end
  end

  property p_select_under_gate;
    @(posedge pclk) disable iff (!presetn)
    (sw.out_src != $past(sw.out_src)) |-> !sw.gate_en && !$past(sw.gate_en);
  endproperty
  a_select_under_gate: assert property (p_select_under_gate)
    else $error("clock select changed with gate open");
endmodule

/* File: rtl/clock_switch_control.sv */
`timescale 1ns/10ps
`include "clock_switch_regs.svh"
module clock_switch_control #(
  parameter int unsigned ADDR_W     = 12,
  parameter int unsigned SETTLE_CYC = `CLKSW_SETTLE_CYC
) (
  // clock and reset
  input  logic              pclk,
  input  logic              presetn,
  // apb slave
  input  logic [ADDR_W-1:0] paddr,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // configuration fuses
  input  logic              switch_enable_fuse,
  input  logic [2:0]        reset_source_fuse,
  input  logic [2:0]        external_osc_mode_fuse,
  input  logic [3:0]        internal_fast_freq_select,
  // oscillator status
  input  logic              external_oscillator_ready,
  input  logic              internal_fast_oscillator_ready,
  input  logic              internal_slow_oscillator_ready,
  input  logic              pll_locked,
  // clock generator controls
  output logic [2:0]        sys_source,
  output logic [3:0]        sys_divider,
  output logic              sys_clock_enable,
  output logic [3:0]        fast_freq,
  output logic [2:0]        external_osc_mode,
  output logic              switch_interrupt_flag
);
  clock_switch_if sw ();

  logic        init_q;
  logic [2:0]  req_src_q;
  logic [3:0]  req_div_q;
  logic [2:0]  act_src_q;
  logic [3:0]  act_div_q;
  logic [2:0]  tgt_src_q;
  logic [3:0]  tgt_div_q;
  logic        hold_q;
  logic        nsr_q;
  logic        switching_q;
  logic        start_q;
  logic        irq_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [3:0]  freq_q;
  logic [2:0]  ext_mode_q;
  logic        init_load;
  logic [2:0]  fuse_src;
  logic [3:0]  fuse_div;
  logic        pending;
  logic        req_ready;
  logic        nsr_set;
  logic        launch;
  logic        wr_req;
  logic        wr_stat;
  logic        done_flag;
  logic [31:0] rd_data;
  logic        rd_err;

  // ----------------------------------------------------------------------
  // source decode
  // ----------------------------------------------------------------------
  // reserved aliases fold onto the fast internal oscillator
  function automatic logic [2:0] eff_src(input logic [2:0] code);
    logic [2:0] r;
    r = code;
    if (code == clock_switch_pkg::SRC_RSVD0 ||
        code == clock_switch_pkg::SRC_RSVD3 ||
        code == clock_switch_pkg::SRC_RSVD4) begin
      r = clock_switch_pkg::SRC_FAST;
    end
    return r;
  endfunction

  // readiness of the oscillator the request names
  always_comb begin
    req_ready = internal_fast_oscillator_ready;
    unique case (clock_switch_pkg::source_t'(eff_src(req_src_q)))
      clock_switch_pkg::SRC_EXT:
        req_ready = external_oscillator_ready;
      clock_switch_pkg::SRC_SLOW:
        req_ready = internal_slow_oscillator_ready;
      clock_switch_pkg::SRC_EXT_PLL4:
        req_ready = external_oscillator_ready && pll_locked;
      clock_switch_pkg::SRC_FAST_PLL2:
        req_ready = internal_fast_oscillator_ready && pll_locked;
      default:
        req_ready = internal_fast_oscillator_ready;
    endcase
  end

  // ----------------------------------------------------------------------
  // reset strap capture
  // ----------------------------------------------------------------------
  // fuses are read on the first edge after release, not under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
    end
  end

  assign init_load = !init_q;
  assign fuse_src  = reset_source_fuse;
  assign fuse_div  = (eff_src(reset_source_fuse) == clock_switch_pkg::SRC_FAST)
                     ? `CLKSW_DIV_RST_FAST : `CLKSW_DIV_RST_OTHER;

  // ----------------------------------------------------------------------
  // switch control
  // ----------------------------------------------------------------------
  assign pending   = (req_src_q != act_src_q) || (req_div_q != act_div_q);
  assign done_flag = !pending && !switching_q;
  assign nsr_set   = init_q && pending && !switching_q && !nsr_q &&
                     req_ready;
  assign launch    = nsr_q && !hold_q && !switching_q && !sw.busy;

  // request register: fuse at start, software later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_src_q <= clock_switch_pkg::SRC_FAST;
      req_div_q <= `CLKSW_DIV_RST_FAST;
    end else if (init_load) begin
      req_src_q <= fuse_src;
      req_div_q <= fuse_div;
    end else if (wr_req && switch_enable_fuse &&
                 pwdata[`CLKSW_SRC_F] != clock_switch_pkg::SRC_RSVD4) begin
      req_src_q <= pwdata[`CLKSW_SRC_F];
      req_div_q <= pwdata[`CLKSW_DIV_F];
    end
  end

  // active selection takes the fuse choice at boot, then follows only a completed switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_src_q <= clock_switch_pkg::SRC_FAST;
      act_div_q <= `CLKSW_DIV_RST_FAST;
    end else if (init_load) begin
      act_src_q <= fuse_src;
      act_div_q <= fuse_div;
    end else if (sw.done) begin
      act_src_q <= tgt_src_q;
      act_div_q <= tgt_div_q;
    end
  end

  // target frozen at launch; boot also loads the fuse choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_src_q   <= clock_switch_pkg::SRC_FAST;
      tgt_div_q   <= `CLKSW_DIV_RST_FAST;
      switching_q <= 1'b0;
      start_q     <= 1'b0;
    end else begin
      start_q <= init_load || launch;
      if (init_load) begin
        tgt_src_q   <= fuse_src;
        tgt_div_q   <= fuse_div;
        switching_q <= 1'b1;
      end else if (launch) begin
        tgt_src_q   <= req_src_q;
        tgt_div_q   <= req_div_q;
        switching_q <= 1'b1;
      end else if (sw.done) begin
        switching_q <= 1'b0;
      end
    end
  end

  // ready flag: set wins, cleared by completion or abandon
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nsr_q <= 1'b0;
    end else begin
      if (sw.done || !pending) begin
        nsr_q <= 1'b0;
      end
      if (nsr_set) begin
        nsr_q <= 1'b1;
      end
    end
  end

  // one pulse per ready event, also while held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= nsr_set;
    end
  end

  // hold bit, software owned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
    end else if (wr_stat) begin
      hold_q <= pwdata[`CLKSW_HOLD_B];
    end
  end

  // configuration pass-through for the oscillators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q     <= '0;
      ext_mode_q <= '0;
    end else begin
      freq_q     <= internal_fast_freq_select;
      ext_mode_q <= external_osc_mode_fuse;
    end
  end

  assign sw.start   = start_q;
  assign sw.tgt_src = eff_src(tgt_src_q);
  assign sw.tgt_div = tgt_div_q;

  clock_switch_sequencer #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .sw      (sw)
  );

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  assign wr_req  = psel && penable && pready_q && pwrite &&
                   paddr == `CLKSW_ADDR_REQUEST;
  assign wr_stat = psel && penable && pready_q && pwrite &&
                   paddr == `CLKSW_ADDR_STATUS;

  // read mux; unimplemented bits stay zero
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    unique case (paddr)
      `CLKSW_ADDR_REQUEST: begin
        rd_data[`CLKSW_SEL_F] = {req_src_q, req_div_q};
      end
      `CLKSW_ADDR_CURRENT: begin
        rd_data[`CLKSW_SEL_F] = {act_src_q, act_div_q};
      end
      `CLKSW_ADDR_STATUS: begin
        rd_data[`CLKSW_HOLD_B] = hold_q;
        rd_data[`CLKSW_DONE_B] = done_flag;
        rd_data[`CLKSW_NSR_B]  = nsr_q;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // one wait-free access phase; answer built during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && rd_err;
      if (psel && !penable && !pwrite) begin
        prdata_q <= rd_data;
      end
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign sys_source            = sw.out_src;
  assign sys_divider           = sw.out_div;
  assign sys_clock_enable      = sw.gate_en;
  assign fast_freq             = freq_q;
  assign external_osc_mode     = ext_mode_q;
  assign switch_interrupt_flag = irq_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_launch;
    nsr_q && !hold_q && !switching_q && !sw.busy;
  endsequence
  sequence s_finish;
    switching_q ##[1:40] sw.done;
  endsequence

  property p_reserved_write;
    wr_req && pwdata[`CLKSW_SRC_F] == 3'h4
      |=> req_src_q == $past(req_src_q) && req_div_q == $past(req_div_q);
  endproperty
  a_reserved_write: assert property (p_reserved_write)
    else $error("reserved source write changed the request");

  property p_fuse_lock;
    init_q && !switch_enable_fuse |=> $stable({req_src_q, req_div_q});
  endproperty
  a_fuse_lock: assert property (p_fuse_lock)
    else $error("request changed with switching disabled");

  property p_boot_values;
    init_q && !$past(init_q)
      |-> req_div_q == ((eff_src(req_src_q) == 3'h6) ? 4'h2 : 4'h0)
          && act_src_q == req_src_q && act_div_q == req_div_q;
  endproperty
  a_boot_values: assert property (p_boot_values)
    else $error("wrong selection after reset");

  property p_ready_event;
    nsr_set |=> nsr_q && switch_interrupt_flag;
  endproperty
  a_ready_event: assert property (p_ready_event)
    else $error("ready event lost");

  property p_hold_blocks;
    nsr_q && hold_q && !switching_q |=> !switching_q && !sw.start;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks)
    else $error("switch started while held");

  property p_launch_completes;
    s_launch |=> s_finish;
  endproperty
  a_launch_completes: assert property (p_launch_completes)
    else $error("switch did not complete in time");

  property p_done_updates;
    sw.done && init_q |=> act_src_q == $past(tgt_src_q) && !nsr_q;
  endproperty
  a_done_updates: assert property (p_done_updates)
    else $error("active fields not updated on switch");

  property p_status_zeros;
    pready_q && !pwrite && $past(paddr) == `CLKSW_ADDR_STATUS
      |-> prdata_q[6:5] == 2'h0 && prdata_q[2:0] == 3'h0;
  endproperty
  a_status_zeros: assert property (p_status_zeros)
    else $error("unimplemented status bits read nonzero");

  property p_done_flag;
    switching_q && !sw.done |-> !done_flag ##1 !done_flag;
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("done flag high during a switch");
endmodule

/* File: tb/tb_clock_switch_control.sv */
`timescale 1ns/10ps
module tb_clock_switch_control;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned S = 4;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sw_en;
  logic [2:0]  rst_src;
  logic [2:0]  ext_mode;
  logic [3:0]  freq_sel;
  logic        ext_rdy;
  logic        fast_rdy;
  logic        slow_rdy;
  logic        pll_rdy;
  logic [2:0]  sys_source;
  logic [3:0]  sys_divider;
  logic [3:0]  fast_freq;
  logic [2:0]  ext_mode_o;
  logic        irq;
  logic        gate;
  int          mismatches;
  int          compares;
  int          irq_cnt;
  int          gate_lo;

  clock_switch_control #(.SETTLE_CYC(S)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_enable_fuse(sw_en), .reset_source_fuse(rst_src),
    .external_osc_mode_fuse(ext_mode),
    .internal_fast_freq_select(freq_sel),
    .external_oscillator_ready(ext_rdy),
    .internal_fast_oscillator_ready(fast_rdy),
    .internal_slow_oscillator_ready(slow_rdy), .pll_locked(pll_rdy),
    .sys_source(sys_source), .sys_divider(sys_divider),
    .sys_clock_enable(gate), .fast_freq(fast_freq),
    .external_osc_mode(ext_mode_o), .switch_interrupt_flag(irq));

  // ----------------------------------------------------------------
  // clock, interrupt pulse counter and gate-low cycle counter
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // counting pulses lets a late or doubled pulse show up
  always @(posedge pclk) if (irq === 1'b1) irq_cnt++;
  always @(posedge pclk) if (gate === 1'b0) gate_lo++;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] rst_div(input logic [2:0] s);
    return (s == 3'h6) ? 4'h2 : 4'h0;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      mismatches++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, {24'h0, v}, d, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  // poll the status register until the switch reports done
  task automatic wait_done();
    logic [31:0] d;
    for (int n = 0; n < 40; n++) begin
      rd(12'h008, d);
      if (d[4] === 1'b1) return;
    end
    mismatches++;
    test_done();
  endtask

  task automatic do_reset(input logic [2:0] f);
    rst_src <= f;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2 * S + 8) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic        e;
    logic [2:0]  s;
    logic [3:0]  v;
    logic [6:0]  cur;
    logic [2:0]  fz[5];
    logic [2:0]  ok[5];
    int          k;
    int          g;
    fz = '{3'h5, 3'h7, 3'h1, 3'h2, 3'h6};
    ok = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sw_en = 1'b1;
    rst_src = 3'h6;
    ext_mode = 3'h0;
    freq_sel = 4'h0;
    {ext_rdy, fast_rdy, slow_rdy, pll_rdy} = 4'hf;
    mismatches = 0;
    compares = 0;
    irq_cnt = 0;
    gate_lo = 0;
    k = $urandom(32'h371e);
    // reset values follow the fuse code
    foreach (fz[i]) begin
      do_reset(fz[i]);
      rd(12'h000, d);
      check("request", {25'h0, fz[i], rst_div(fz[i])}, d);
      rd(12'h004, d);
      check("current", {25'h0, fz[i], rst_div(fz[i])}, d);
      rd(12'h008, d);
      check("status", 32'h10, d);
      check("sys", {25'h0, fz[i], rst_div(fz[i])},
            {25'h0, sys_source, sys_divider});
      check("gate", 32'h1, {31'h0, gate});
    end
    $display("test reset done");
    // refused writes: reserved code, fuse low, current; unmapped read errors
    wr(12'h000, 8'h45);
    rd(12'h000, d);
    check("request", 32'h62, d);
    sw_en <= 1'b0;
    wr(12'h000, 8'h51);
    rd(12'h000, d);
    check("request", 32'h62, d);
    sw_en <= 1'b1;
    wr(12'h004, 8'hf3);
    rd(12'h004, d);
    check("current", 32'h62, d);
    apb(1'b0, 12'h00c, 32'h0, d, e);
    check("pslverr", 32'h1, {31'h0, e});
    wr(12'h008, 8'hff);
    rd(12'h008, d);
    check("status", 32'h90, d);
    wr(12'h008, 8'h00);
    $display("test refuse done");
    // random switches, hold clear
    cur = 7'h62;
    for (int i = 0; i < 8; i++) begin
      s = ok[$urandom % 5];
      v = 4'($urandom % 10);
      if ({s, v} == cur) v = (v == 4'h9) ? 4'h0 : v + 4'h1;
      k = irq_cnt;
      g = gate_lo;
      wr(12'h000, {1'b0, s, v});
      wait_done();
      check("irq count", 32'(k + 1), 32'(irq_cnt));
      check("gate low", 32'(2 * S + 1), 32'(gate_lo - g));
      rd(12'h004, d);
      check("current", {25'h0, s, v}, d);
      check("sys", {25'h0, s, v},
            {25'h0, sys_source, sys_divider});
      cur = {s, v};
    end
    $display("test switch done");
    // hold: pending switch waits for software
    s = (cur[6:4] == 3'h5) ? 3'h7 : 3'h5;
    wr(12'h008, 8'h80);
    ext_rdy <= (s != 3'h7);
    slow_rdy <= (s != 3'h5);
    k = irq_cnt;
    g = gate_lo;
    wr(12'h000, {1'b0, s, 4'h3});
    repeat (10) @(posedge pclk);
    rd(12'h008, d);
    check("status", 32'h80, d);
    ext_rdy <= 1'b1;
    slow_rdy <= 1'b1;
    repeat (4) @(posedge pclk);
    check("irq count", 32'(k + 1), 32'(irq_cnt));
    rd(12'h008, d);
    check("status", 32'h88, d);
    repeat (20) @(posedge pclk);
    check("sys", {25'h0, cur}, {25'h0, sys_source, sys_divider});
    check("gate low", 32'(g), 32'(gate_lo));
    wr(12'h008, 8'h00);
    wait_done();
    rd(12'h008, d);
    check("status", 32'h10, d);
    check("sys", {25'h0, s, 4'h3},
          {25'h0, sys_source, sys_divider});
    $display("test hold done");
    // abandon: copy the active selection back while held
    wr(12'h008, 8'h80);
    wr(12'h000, {1'b0, s, 4'h5});
    repeat (4) @(posedge pclk);
    rd(12'h008, d);
    check("status", 32'h88, d);
    wr(12'h000, {1'b0, s, 4'h3});
    rd(12'h008, d);
    check("status", 32'h90, d);
    check("sys", {25'h0, s, 4'h3},
          {25'h0, sys_source, sys_divider});
    wr(12'h008, 8'h00);
    $display("test abandon done");
    // fuse and frequency pass-through
    freq_sel <= 4'($urandom);
    ext_mode <= 3'($urandom);
    repeat (3) @(posedge pclk);
    check("fast_freq", {28'h0, freq_sel}, {28'h0, fast_freq});
    check("ext_mode", {29'h0, ext_mode}, {29'h0, ext_mode_o});
    $display("test pass-through done");
    // reserved code 000 steers the mux like the fast oscillator
    wr(12'h000, 8'h01);
    repeat (40) @(posedge pclk);
    check("sys_source", 32'h6, {29'h0, sys_source});
    rd(12'h000, d);
    check("request", 32'h01, d);
    $display("test reserved done");
    test_done();
  end
endmodule
